// >>> verilog/sspc_ctrl.sv
// control, status and rate logic of the synchronous serial port
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - i2c master: buffer write while bus not ready sets write collision
// - colliding buffer write is discarded, buffer keeps old contents
// - slave: buffer write during transmit sets collision; software clears
// - byte arriving with unread buffer sets overflow, not in master
// - enable hands serial pins to the port, else general i/o
// - spi clock idles at the polarity bit level
// - i2c slave holds clock low while release bit is zero
// - codes 0000/0001/0010 divide by 4/16/64; 0011 uses timer2 match/4
// - codes 0100/0101 spi slave, with or without select pin
// - i2c slave with 7-bit and 10-bit addressing codes
// - i2c slave codes also interrupting on start and stop
// - codes 1000 and 1010 clock at fosc over 4*(reload+1) for reload below 128
// - code 1011 firmware i2c master, slave idle
module sspc_ctrl (
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic ENG_BUSY_IN,
	input wire logic ENG_BUS_OK_IN,
	input wire logic ENG_RX_BYTE_IN,
	input wire logic [7:0] ENG_RX_DATA_IN,
	input wire logic ENG_START_IN,
	input wire logic ENG_STOP_IN,
	input wire logic TIMER2_MATCH_PULSE_IN,
	output logic [7:0] TX_DATA_OUT,
	output logic TX_LOAD_OUT,
	output logic SHIFT_TICK_OUT,
	output sspc_pkg::sspc_cfg_type CFG_OUT,
	output logic IRQ_OUT
);
	logic [7:0] ctrl_q;
	logic [7:0] buf_q;
	logic buf_full_q;
	logic [7:0] reload_q;
	logic [7:0] div_cnt_q;
	logic [7:0] div_cnt_d;
	logic [7:0] div_top;
	logic tick_q;
	logic t2_half_q;
	logic [sspc_pkg::IRQ_W-1:0] irq_stat_q;
	logic [sspc_pkg::IRQ_W-1:0] irq_en_q;
	logic wr_acc;
	logic rd_acc;
	logic buf_wr;
	logic buf_rd;
	logic collide;
	logic overflow;
	logic is_master;
	logic [3:0] mode;
	sspc_pkg::sspc_engine_type eng;
	sspc_pkg::sspc_cfg_type cfg_d;

	function automatic logic mode_is_master(input logic [3:0] m);
		case (m)
			sspc_pkg::SPI_M_DIV4, sspc_pkg::SPI_M_DIV16,
			sspc_pkg::SPI_M_DIV64, sspc_pkg::SPI_M_TMR2,
			sspc_pkg::SPI_M_BRG, sspc_pkg::I2C_M_BRG,
			sspc_pkg::I2C_M_FW: mode_is_master = 1'b1;
			default: mode_is_master = 1'b0;
		endcase
	endfunction

	function automatic logic mode_is_spi(input logic [3:0] m);
		case (m)
			sspc_pkg::SPI_M_DIV4, sspc_pkg::SPI_M_DIV16,
			sspc_pkg::SPI_M_DIV64, sspc_pkg::SPI_M_TMR2,
			sspc_pkg::SPI_M_BRG, sspc_pkg::SPI_S_SEL,
			sspc_pkg::SPI_S_NOSEL: mode_is_spi = 1'b1;
			default: mode_is_spi = 1'b0;
		endcase
	endfunction

	assign eng.busy = ENG_BUSY_IN;
	assign eng.bus_ok = ENG_BUS_OK_IN;
	assign eng.rx_byte = ENG_RX_BYTE_IN;
	assign eng.start_seen = ENG_START_IN;
	assign eng.stop_seen = ENG_STOP_IN;

	assign mode = ctrl_q[3:0];
	assign is_master = mode_is_master(mode);
	assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign rd_acc = PSEL_IN && PENABLE_IN && !PWRITE_IN;
	assign buf_wr = wr_acc && (PADDR_IN == sspc_pkg::BUF_ADDR);
	assign buf_rd = rd_acc && (PADDR_IN == sspc_pkg::BUF_ADDR);
	// every mode needs engine not busy; i2c master also needs idle bus
	assign collide = buf_wr && (eng.busy ||
		(is_master && !mode_is_spi(mode) && !eng.bus_ok));
	assign overflow = eng.rx_byte && buf_full_q && !is_master;

	// apb answers in the access cycle, zero wait states
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			PRDATA_OUT <= 32'h0000_0000;
			PREADY_OUT <= 1'b0;
			PSLVERR_OUT <= 1'b0;
		end else begin
			PREADY_OUT <= PSEL_IN && !PENABLE_IN;
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT <= 32'h0000_0000;
			if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
				case (PADDR_IN)
					sspc_pkg::CTRL_ONE_ADDR: PRDATA_OUT <= {24'h0, ctrl_q};
					sspc_pkg::BUF_ADDR: PRDATA_OUT <= {24'h0, buf_q};
					sspc_pkg::RELOAD_ADDR: PRDATA_OUT <= {24'h0, reload_q};
					sspc_pkg::STATUS_ADDR:
						PRDATA_OUT <= {30'h0, buf_full_q, eng.busy};
					sspc_pkg::IRQ_STAT_ADDR:
						PRDATA_OUT <= {28'h0, irq_stat_q};
					sspc_pkg::IRQ_EN_ADDR: PRDATA_OUT <= {28'h0, irq_en_q};
					default: PSLVERR_OUT <= 1'b1;
				endcase
			end else if (PSEL_IN && !PENABLE_IN) begin
				case (PADDR_IN)
					sspc_pkg::CTRL_ONE_ADDR, sspc_pkg::BUF_ADDR,
					sspc_pkg::RELOAD_ADDR, sspc_pkg::IRQ_CLR_ADDR,
					sspc_pkg::IRQ_EN_ADDR: PSLVERR_OUT <= 1'b0;
					default: PSLVERR_OUT <= 1'b1;
				endcase
			end
		end
	end

	// control register; flags set by hardware, zero-write clears
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			ctrl_q <= sspc_pkg::CTRL_ONE_RESET;
		end else begin
			if (wr_acc && PADDR_IN == sspc_pkg::CTRL_ONE_ADDR) begin
				ctrl_q[5:0] <= PWDATA_IN[5:0];
				if (!PWDATA_IN[sspc_pkg::WRITE_COLLISION_FLAG_BIT])
					ctrl_q[sspc_pkg::WRITE_COLLISION_FLAG_BIT] <= 1'b0;
				if (!PWDATA_IN[sspc_pkg::ROV_BIT])
					ctrl_q[sspc_pkg::ROV_BIT] <= 1'b0;
			end
			// set beats clear in the same cycle
			if (collide)
				ctrl_q[sspc_pkg::WRITE_COLLISION_FLAG_BIT] <= 1'b1;
			if (overflow)
				ctrl_q[sspc_pkg::ROV_BIT] <= 1'b1;
		end
	end

	// transfer buffer: tx writes and rx bytes
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			buf_q <= sspc_pkg::BUF_RESET;
			buf_full_q <= 1'b0;
			TX_DATA_OUT <= sspc_pkg::BUF_RESET;
			TX_LOAD_OUT <= 1'b0;
		end else begin
			TX_LOAD_OUT <= buf_wr && !collide;
			if (buf_wr && !collide) begin
				buf_q <= PWDATA_IN[7:0];
				TX_DATA_OUT <= PWDATA_IN[7:0];
				buf_full_q <= 1'b0;
			end else if (eng.rx_byte && !overflow) begin
				buf_q <= ENG_RX_DATA_IN; // overflow byte dropped
				buf_full_q <= 1'b1;
			end else if (buf_rd) begin
				buf_full_q <= 1'b0;
			end
			// colliding write leaves buffer untouched
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN)
			reload_q <= sspc_pkg::RELOAD_RESET;
		else if (wr_acc && PADDR_IN == sspc_pkg::RELOAD_ADDR)
			reload_q <= PWDATA_IN[7:0]; // values trusted
	end

	// shift tick: one per half serial clock period (fosc/(2*(top+1)))
	always_comb begin
		case (mode)
			sspc_pkg::SPI_M_DIV4: div_top = sspc_pkg::FIXED_DIV_LOW;
			sspc_pkg::SPI_M_DIV16: div_top = sspc_pkg::FIXED_DIV_MID;
			sspc_pkg::SPI_M_DIV64: div_top = sspc_pkg::FIXED_DIV_HIGH;
			// 2*(reload+1)-1 half period for fosc/(4*(reload+1))
			default: div_top = {reload_q[6:0], 1'b1};
		endcase
	end

	always_comb begin
		div_cnt_d = div_cnt_q + 8'h01;
		if (div_cnt_q >= div_top || !ctrl_q[sspc_pkg::EN_BIT] || !eng.busy)
			div_cnt_d = 8'h00;
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			div_cnt_q <= 8'h00;
			tick_q <= 1'b0;
			t2_half_q <= 1'b0;
		end else begin
			div_cnt_q <= div_cnt_d;
			if (TIMER2_MATCH_PULSE_IN)
				t2_half_q <= !t2_half_q;
			if (mode == sspc_pkg::SPI_M_TMR2)
				tick_q <= TIMER2_MATCH_PULSE_IN && t2_half_q
					&& eng.busy && ctrl_q[sspc_pkg::EN_BIT];
			else
				tick_q <= is_master && eng.busy
					&& ctrl_q[sspc_pkg::EN_BIT]
					&& div_cnt_q >= div_top;
		end
	end
	assign SHIFT_TICK_OUT = tick_q;

	always_comb begin
		cfg_d.pins_to_port = ctrl_q[sspc_pkg::EN_BIT];
		cfg_d.is_spi = mode_is_spi(mode);
		cfg_d.is_master = is_master;
		cfg_d.select_used = (mode == sspc_pkg::SPI_S_SEL);
		cfg_d.addr_ten = (mode == sspc_pkg::I2C_S_10)
			|| (mode == sspc_pkg::I2C_S_10_SP);
		cfg_d.start_stop_irq = (mode == sspc_pkg::I2C_S_7_SP)
			|| (mode == sspc_pkg::I2C_S_10_SP);
		cfg_d.slave_idle = (mode == sspc_pkg::I2C_M_FW);
		cfg_d.sclk_idle_high = mode_is_spi(mode)
			&& ctrl_q[sspc_pkg::CKP_BIT];
		cfg_d.hold_clock_low = ctrl_q[sspc_pkg::EN_BIT]
			&& !mode_is_spi(mode) && !is_master
			&& !ctrl_q[sspc_pkg::CKP_BIT];
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN)
			CFG_OUT <= '0;
		else
			CFG_OUT <= cfg_d;
	end

	// sticky interrupt status, set beats clear
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			irq_stat_q <= sspc_pkg::IRQ_RESET;
			irq_en_q <= sspc_pkg::IRQ_RESET;
			IRQ_OUT <= 1'b0;
		end else begin
			if (wr_acc && PADDR_IN == sspc_pkg::IRQ_EN_ADDR)
				irq_en_q <= PWDATA_IN[sspc_pkg::IRQ_W-1:0];
			irq_stat_q <= (irq_stat_q & ~((wr_acc
				&& PADDR_IN == sspc_pkg::IRQ_CLR_ADDR)
				? PWDATA_IN[sspc_pkg::IRQ_W-1:0] : sspc_pkg::IRQ_RESET))
				| {cfg_d.start_stop_irq && eng.stop_seen,
				cfg_d.start_stop_irq && eng.start_seen,
				overflow, collide};
			IRQ_OUT <= |(irq_stat_q & irq_en_q);
		end
	end
endmodule
`default_nettype wire

// >>> verilog/sspc_pkg.sv
// package for the serial port control register bank
package sspc_pkg;
	// apb word addresses (byte offsets)
	localparam logic [11:0] CTRL_ONE_ADDR = 12'h000;
	localparam logic [11:0] BUF_ADDR = 12'h004;
	localparam logic [11:0] RELOAD_ADDR = 12'h008;
	localparam logic [11:0] STATUS_ADDR = 12'h00C;
	localparam logic [11:0] IRQ_STAT_ADDR = 12'h010;
	localparam logic [11:0] IRQ_CLR_ADDR = 12'h014;
	localparam logic [11:0] IRQ_EN_ADDR = 12'h018;
	// control register fields
	localparam int WRITE_COLLISION_FLAG_BIT = 7;
	localparam int ROV_BIT = 6;
	localparam int EN_BIT = 5;
	localparam int CKP_BIT = 4;
	localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam logic [7:0] BUF_RESET = 8'h00;
	localparam logic [7:0] FIXED_DIV_LOW = 8'h01;
	localparam logic [7:0] FIXED_DIV_MID = 8'h07;
	localparam logic [7:0] FIXED_DIV_HIGH = 8'h1F;
	// interrupt status bits
	localparam int IRQ_WRITE_COLLISION_FLAG = 0;
	localparam int IRQ_ROV = 1;
	localparam int IRQ_START = 2;
	localparam int IRQ_STOP = 3;
	localparam int IRQ_W = 4;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
	// port mode codes
	typedef enum logic [3:0] {
		SPI_M_DIV4 = 4'h0,
		SPI_M_DIV16 = 4'h1,
		SPI_M_DIV64 = 4'h2,
		SPI_M_TMR2 = 4'h3,
		SPI_S_SEL = 4'h4,
		SPI_S_NOSEL = 4'h5,
		I2C_S_7 = 4'h6,
		I2C_S_10 = 4'h7,
		I2C_M_BRG = 4'h8,
		SPI_M_BRG = 4'hA,
		I2C_M_FW = 4'hB,
		I2C_S_7_SP = 4'hE,
		I2C_S_10_SP = 4'hF
	} sspc_mode_type;
	// events reported by the shift engine
	typedef struct packed {
		logic busy;
		logic bus_ok;
		logic rx_byte;
		logic start_seen;
		logic stop_seen;
	} sspc_engine_type;
	// decoded configuration handed to the engine and pins
	typedef struct packed {
		logic pins_to_port;
		logic is_spi;
		logic is_master;
		logic select_used;
		logic addr_ten;
		logic start_stop_irq;
		logic slave_idle;
		logic sclk_idle_high;
		logic hold_clock_low;
	} sspc_cfg_type;
endpackage

// >>> test/sspc_monitor.sv
// port checks for the serial port control block
`timescale 1ns/1ns
`default_nettype none
module sspc_monitor (
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PREADY_OUT,
	input wire logic ENG_BUSY_IN,
	input wire logic ENG_BUS_OK_IN,
	input wire logic [7:0] TX_DATA_OUT,
	input wire logic TX_LOAD_OUT,
	input wire sspc_pkg::sspc_cfg_type CFG_OUT,
	input wire logic IRQ_OUT
);
	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (RST_IN);
	wire logic acc = PSEL_IN && PENABLE_IN && PWRITE_IN;
	wire logic buf_wr = acc && PADDR_IN == sspc_pkg::BUF_ADDR
		&& CFG_OUT.pins_to_port;
	wire logic free = CFG_OUT.is_spi || !CFG_OUT.is_master || ENG_BUS_OK_IN;
	sequence loaded;
		TX_LOAD_OUT && TX_DATA_OUT == $past(PWDATA_IN[7:0]) ##1 !TX_LOAD_OUT;
	endsequence
	sequence cfg_took;
		##2 CFG_OUT.pins_to_port == $past(PWDATA_IN[5], 2)
			&& (!CFG_OUT.is_spi || CFG_OUT.sclk_idle_high == $past(PWDATA_IN[4], 2));
	endsequence
	ready_access_a: assert property (PSEL_IN && PENABLE_IN |-> PREADY_OUT)
		else $error("no ready in access phase");
	ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready longer than one cycle");
	idle_data_a: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
		else $error("read data outside answer");
	buf_load_a: assert property (buf_wr && !ENG_BUSY_IN && free |=> loaded)
		else $error("buffer write not loaded");
	busy_block_a: assert property (buf_wr && ENG_BUSY_IN |=> !TX_LOAD_OUT)
		else $error("load during transfer");
	bus_block_a: assert property (buf_wr && !free |=> !TX_LOAD_OUT)
		else $error("load while bus not ready");
	cfg_follow_a: assert property (acc && PADDR_IN == 12'h000 |-> cfg_took)
		else $error("config does not follow control");
	reset_quiet_a: assert property (disable iff (1'b0) RST_IN
		|=> !PREADY_OUT && !IRQ_OUT && !TX_LOAD_OUT)
		else $error("outputs active after reset");
endmodule
`default_nettype wire

// >>> test/sspc_eng_model.sv
// shift engine and bus peer model for the control block
`timescale 1ns/1ns
`default_nettype none
module sspc_eng_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic load_in,
	input wire logic slow_in,
	input wire logic ok_in,
	input wire logic rx_in,
	input wire logic [1:0] cond_in,
	input wire logic [7:0] val_in,
	output var sspc_pkg::sspc_engine_type ev_out,
	output logic [7:0] data_out
);
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ev_out <= '0;
			data_out <= 8'h00;
		end else begin
			ev_out <= {load_in | ev_out.busy & slow_in, ok_in, rx_in, cond_in};
			// data line inverts every cycle between bytes
			data_out <= rx_in ? val_in : ~data_out;
		end
	end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, t2 = 0, slow = 0;
	logic ok = 1, rx = 0, rdy, err, irq, txl, tick;
	logic [1:0] cond = 0;
	logic [7:0] rxv = 0, txd, rxd;
	logic [11:0] pa = 0;
	logic [11:0] ra[7] = '{12'h0, 12'h8, 12'hC, 12'h10, 12'h18, 12'h1C, 12'h14};
	logic [31:0] pwd = 0, prd;
	logic [32:0] q[$];
	logic [32:0] e;
	logic [15:0] ms = 16'h043F, mm = 16'h0D0F, mt = 16'h8080, mi = 16'hC000;
	int failures = 0, checked = 0, cyc = 0, seed = 32'h2D76, k, n, r;
	int tc[5] = '{0, 1, 2, 3, 10}, hv[5] = '{2, 8, 32, 10, 0};
	sspc_pkg::sspc_cfg_type cfg;
	sspc_pkg::sspc_engine_type ev;
	initial forever #20 clk = ~clk;
	sspc_ctrl dut (.SYS_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
		.PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(err),
		.ENG_BUSY_IN(ev.busy), .ENG_BUS_OK_IN(ev.bus_ok),
		.ENG_RX_BYTE_IN(ev.rx_byte), .ENG_RX_DATA_IN(rxd),
		.ENG_START_IN(ev.start_seen), .ENG_STOP_IN(ev.stop_seen),
		.TIMER2_MATCH_PULSE_IN(t2), .TX_DATA_OUT(txd), .TX_LOAD_OUT(txl),
		.SHIFT_TICK_OUT(tick), .CFG_OUT(cfg), .IRQ_OUT(irq));
	sspc_eng_model eng (.clk_in(clk), .rst_in(rst), .load_in(txl),
		.slow_in(slow), .ok_in(ok), .rx_in(rx), .cond_in(cond), .val_in(rxv),
		.ev_out(ev), .data_out(rxd));
	task automatic chk(string s, logic [32:0] v, logic [32:0] x);
		checked++;
		if (v !== x) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", s, x, v);
		end
	endtask
	task automatic pulse(logic b, logic [1:0] c, logic [7:0] d);
		rx <= b;
		cond <= c;
		rxv <= d;
		@(posedge clk);
		rx <= 0;
		cond <= 0;
		repeat (3) @(posedge clk);
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [7:0] d);
		q.push_back({!(a inside {12'h0, 12'h4, 12'h8, 12'hC, 12'h10, 12'h14,
			12'h18}) || (!w && a == 12'h14), 24'h0, d});
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= {24'($random(seed)), d};
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (!rdy);
		psel <= 0;
		pen <= 0;
		repeat (2) @(posedge clk);
	endtask
	task test_done;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// answers are matched in order against the notes of the driver
	always @(posedge clk) begin
		t2 <= cyc % 5 == 0;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			test_done;
		end
		if (psel && pen && rdy) begin
			e = q.pop_front();
			chk("apb", {err, pwr ? 32'h0 : prd}, pwr ? {e[32], 32'h0} : e);
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		foreach (ra[i]) apb(0, ra[i], 8'h00);
		for (int c = 0; c < 16; c++) begin
			if (c inside {9, 12, 13}) continue;
			r = $random(seed);
			apb(1, 12'h0, {3'b001, r[0], c[3:0]});
			e = {1'b1, ms[c], mm[c], 1'b0, mt[c], mi[c], c == 11,
				ms[c] & r[0], !(ms[c] | mm[c] | r[0])};
			chk("cfg", cfg & 9'h1DF, e);
			if (ms[c] && !mm[c]) chk("sel", cfg.select_used, c == 4);
		end
		r = 3 + {$random(seed)} % 5;
		apb(1, 12'h8, r[7:0]);
		foreach (tc[i]) begin
			apb(1, 12'h0, {4'h2, tc[i][3:0]});
			slow <= 1;
			apb(1, 12'h4, 8'h00);
			for (k = 0; !tick && k < 99; k++) @(negedge clk);
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (!tick && n < 99);
			chk("tick", n, tc[i] == 10 ? 2 * (r + 1) : hv[i]);
			@(posedge clk) slow <= 0;
			repeat (3) @(posedge clk);
		end
		apb(1, 12'h18, 8'h0F);
		apb(1, 12'h0, 8'h24);
		slow <= 1;
		apb(1, 12'h4, 8'h5A);
		apb(1, 12'h4, 8'hA5);
		chk("txd", txd, 8'h5A);
		apb(0, 12'h0, 8'hA4);
		apb(0, 12'h10, 8'h01);
		chk("irq", irq, 1'b1);
		apb(1, 12'h18, 8'h00);
		chk("irq", irq, 1'b0);
		apb(1, 12'h18, 8'h0F);
		apb(1, 12'h14, 8'h01);
		apb(0, 12'h10, 8'h00);
		apb(1, 12'h0, 8'hA4);
		slow <= 0;
		apb(0, 12'h0, 8'hA4);
		apb(1, 12'h0, 8'h24);
		apb(0, 12'h0, 8'h24);
		pulse(1, 0, 8'h3C);
		apb(0, 12'hC, 8'h02);
		pulse(1, 0, 8'hC3);
		apb(0, 12'h0, 8'h64);
		apb(0, 12'h10, 8'h02);
		apb(0, 12'h4, 8'h3C);
		apb(1, 12'h0, 8'h20);
		pulse(1, 0, 8'h11);
		pulse(1, 0, 8'h22);
		apb(0, 12'h0, 8'h20);
		ok <= 0;
		apb(1, 12'h0, 8'h28);
		apb(1, 12'h4, 8'h77);
		apb(0, 12'h0, 8'hA8);
		ok <= 1;
		apb(1, 12'h0, 8'h28);
		apb(1, 12'h4, 8'h77);
		apb(0, 12'h0, 8'h28);
		apb(1, 12'h14, 8'h0F);
		apb(1, 12'h0, 8'h26);
		pulse(0, 3, 8'h00);
		apb(0, 12'h10, 8'h00);
		apb(1, 12'h0, 8'h2E);
		pulse(0, 3, 8'h00);
		apb(0, 12'h10, 8'h0C);
		chk("irq", irq, 1'b1);
		test_done;
	end
endmodule
bind sspc_ctrl sspc_monitor mon (.*);
`default_nettype wire
